// ===== logic/char_fifo.v
// Character FIFO, fixed depth, with level count and synchronous flush.
// Assumes one clock; flush and reset empty it in one edge.
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defines.vh"

module char_fifo #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             flush,
  input  wire             wr_valid,
  output wire             wr_ready,
  input  wire [WIDTH-1:0] wr_data,
  output wire             rd_valid,
  input  wire             rd_ready,
  output wire [WIDTH-1:0] rd_data,
  output wire [6:0]       level
);

  reg [WIDTH-1:0]         mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0]      wp_reg;
  reg [`FIFO_AW-1:0]      rp_reg;
  reg [6:0]               cnt_reg;
  wire                    push;
  wire                    pop;

  assign wr_ready = (cnt_reg != `FIFO_DEPTH);
  assign rd_valid = (cnt_reg != 7'h00);
  assign rd_data  = mem[rp_reg];
  assign level    = cnt_reg;
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Storage has no reset; only pointers matter
  always @(posedge clk)
  begin
    if (push)
      mem[wp_reg] <= wr_data;
  end

  always @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      wp_reg  <= {`FIFO_AW{1'b0}};
      rp_reg  <= {`FIFO_AW{1'b0}};
      cnt_reg <= 7'h00;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 6'h01;
      if (pop)
        rp_reg <= rp_reg + 6'h01;
      if (push && !pop)
        cnt_reg <= cnt_reg + 7'h01;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 7'h01;
    end
  end

endmodule // char_fifo

`default_nettype wire

// ===== logic/uart_flow_ctrl.v
// UART core with 64-entry FIFOs, baud divisor, trigger levels and
// automatic request/clear-to-send flow control.
// Assumes a single 50 MHz clock, registers on a plain strobe port,
// serial pins asynchronous to the clock.
//
// Notes on behaviour
// - Request-to-send pin is active low; request bit set drives it low.
// - After any reset the request-to-send pin stands high.
// - Request-to-send follows receive flow only with auto request enabled.
// - Clear-to-send state is readable in modem-status bit 4.
// - Clear-to-send gates transmission only with auto clear enabled.
// - Loopback disables the transmit pin and routes transmit data to the receiver.
// - Loopback ignores the receive pin; receiver hears only internal transmit data.
// - Hardware reset is active low and resets the device.
// - Both FIFOs hold 64 characters; receive entries carry three error bits.
// - Baud generator divides the clock by a 16-bit divisor, 1 to 65535.
// - Receive and transmit trigger levels are set independently, fixed or programmed.
// - After reset the FIFO enable bit is clear, so both triggers act at one character.
// - Zero programmed trigger register means the fixed level in FIFO control.
// - Auto clear and auto request enable bits are independent, adjacent bits.
// - With auto clear, a character starts only while clear-to-send is active.
// - Auto request asserts with room, deasserts when full, per threshold register.
// - Zero threshold register means auto request halts at the receive trigger level, resuming one below it.
// - Both autos with request looped to clear: sends only while receiver has room.
// - Request stays active while receive level is below the low-nibble halt level.
// - After halt, request reasserts once level reaches the high-nibble resume level.
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defines.vh"

module uart_flow_ctrl (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       rx_pin,
  input  wire       cts_n_pin,
  output reg        tx_pin,
  output reg        rts_n_pin,
  output reg        rx_trig_hit,
  output reg        tx_trig_hit
);

  localparam [1:0] TX_IDLE = 2'b01;
  localparam [1:0] TX_SEND = 2'b10;
  localparam [1:0] RX_IDLE = 2'b01;
  localparam [1:0] RX_RECV = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  reg [7:0]  div_lo_reg;
  reg [7:0]  div_hi_reg;
  reg [7:0]  fifo_control_reg;
  reg [7:0]  modem_control_reg;
  reg [7:0]  enhanced_feature_reg;
  reg [7:0]  flow_threshold_reg;
  reg [7:0]  trigger_level_reg;
  reg        overrun_reg;

  wire       wr_data_sel = wr_stb && (addr == `ADDR_DATA);
  wire       rd_data_sel = rd_stb && (addr == `ADDR_DATA);
  wire       rd_lsr_sel  = rd_stb && (addr == `ADDR_LINE_STAT);
  wire       wr_fcr_sel  = wr_stb && (addr == `ADDR_FIFO_CTRL);
  wire       rx_flush    = wr_fcr_sel && wdata[`FCR_RX_FLUSH];
  wire       tx_flush    = wr_fcr_sel && wdata[`FCR_TX_FLUSH];
  wire       loopback    = modem_control_reg[`MCR_LOOP];
  wire       fifo_en     = fifo_control_reg[`FCR_FIFO_EN];
  wire       auto_rts    = enhanced_feature_reg[`EFR_AUTO_RTS];
  wire       auto_cts    = enhanced_feature_reg[`EFR_AUTO_CTS];

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      div_lo_reg           <= `DIV_LO_RST;
      div_hi_reg           <= `DIV_HI_RST;
      fifo_control_reg     <= `FCR_RST;
      modem_control_reg    <= `MCR_RST;
      enhanced_feature_reg <= `EFR_RST;
      flow_threshold_reg   <= `TCR_RST;
      trigger_level_reg    <= `TLR_RST;
    end
    else if (wr_stb)
    begin
      case (addr)
        `ADDR_DIV_LO:     div_lo_reg           <= wdata;
        `ADDR_DIV_HI:     div_hi_reg           <= wdata;
        // Flush bits are pulses, not stored
        `ADDR_FIFO_CTRL:  fifo_control_reg     <= {wdata[7:3], 2'b00, wdata[0]};
        `ADDR_MODEM_CTRL: modem_control_reg    <= wdata;
        `ADDR_ENH_FEAT:   enhanced_feature_reg <= wdata;
        `ADDR_FLOW_THR:   flow_threshold_reg   <= wdata;
        `ADDR_TRIG_LVL:   trigger_level_reg    <= wdata;
        default:          div_lo_reg           <= div_lo_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: accepted once stages two and three agree
  reg [2:0]  rx_sync_reg;
  reg [2:0]  cts_sync_reg;
  reg        rx_filt_reg;
  reg        cts_n_filt_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_sync_reg    <= 3'h7;
      cts_sync_reg   <= 3'h7;
      rx_filt_reg    <= 1'b1;
      cts_n_filt_reg <= 1'b1;
    end
    else
    begin
      rx_sync_reg  <= {rx_sync_reg[1:0], rx_pin};
      cts_sync_reg <= {cts_sync_reg[1:0], cts_n_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2])
        rx_filt_reg <= rx_sync_reg[2];
      if (cts_sync_reg[1] == cts_sync_reg[2])
        cts_n_filt_reg <= cts_sync_reg[2];
    end
  end

  // In loopback the request output feeds clear-to-send internally
  wire       cts_active = loopback ? ~rts_n_pin : ~cts_n_filt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: one tick per divisor count, 16 ticks per bit
  wire [15:0] div_val = {div_hi_reg, div_lo_reg};
  // Zero is illegal; treat it as one rather than stall
  wire [15:0] div_eff = (div_val == 16'h0000) ? 16'h0001 : div_val;
  reg  [15:0] baud_cnt_reg;
  reg         tick_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      baud_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end
    else if (baud_cnt_reg >= div_eff - 16'h0001)
    begin
      baud_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end
    else
    begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs
  wire                  txf_ready;
  wire                  txf_valid;
  wire [7:0]            txf_data;
  wire [6:0]            txf_level;
  wire                  txf_pop;
  wire                  rxf_ready;
  wire                  rxf_valid;
  wire [`RX_ENTRY_W-1:0] rxf_data;
  wire [6:0]            rxf_level;
  wire                  rx_push;
  wire [`RX_ENTRY_W-1:0] rx_entry;

  // Writes to a full transmit FIFO are dropped
  char_fifo #(.WIDTH(8)) tx_fifo (
    .clk      (sys_clk),
    .nrst     (nrst),
    .flush    (tx_flush),
    .wr_valid (wr_data_sel),
    .wr_ready (txf_ready),
    .wr_data  (wdata),
    .rd_valid (txf_valid),
    .rd_ready (txf_pop),
    .rd_data  (txf_data),
    .level    (txf_level)
  );

  // Entry: break, framing error, parity error, character
  char_fifo #(.WIDTH(`RX_ENTRY_W)) rx_fifo (
    .clk      (sys_clk),
    .nrst     (nrst),
    .flush    (rx_flush),
    .wr_valid (rx_push),
    .wr_ready (rxf_ready),
    .wr_data  (rx_entry),
    .rd_valid (rxf_valid),
    .rd_ready (rd_data_sel),
    .rd_data  (rxf_data),
    .level    (rxf_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: start, eight data bits, one stop bit
  reg [1:0]  tx_state_reg;
  reg [9:0]  tx_shift_reg;
  reg [3:0]  tx_os_reg;
  reg [3:0]  tx_bit_reg;
  reg        tx_line_reg;

  // Flow checked only between characters; one in flight completes
  wire       tx_go = (!auto_cts || cts_active);
  assign txf_pop = (tx_state_reg == TX_IDLE) && tick_reg && txf_valid && tx_go;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 10'h3ff;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
      tx_line_reg  <= 1'b1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          tx_line_reg <= 1'b1;
          if (txf_pop)
          begin
            tx_shift_reg <= {1'b1, txf_data, 1'b0};
            tx_os_reg    <= 4'h0;
            tx_bit_reg   <= 4'h0;
            tx_line_reg  <= 1'b0;
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tick_reg)
          begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_os_reg == `OVERSAMPLE_LAST)
            begin
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_line_reg  <= tx_shift_reg[1];
              tx_bit_reg   <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == `FRAME_LAST_BIT)
              begin
                tx_line_reg  <= 1'b1;
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start found on a low tick, samples taken mid-bit
  wire       rx_in = loopback ? tx_line_reg : rx_filt_reg;
  reg [1:0]  rx_state_reg;
  reg [7:0]  rx_shift_reg;
  reg [3:0]  rx_os_reg;
  reg [3:0]  rx_bit_reg;

  wire       rx_sample = (rx_state_reg == RX_RECV) && tick_reg &&
                         (rx_os_reg == `SAMPLE_POINT);
  wire       rx_stop   = rx_sample && (rx_bit_reg == `FRAME_LAST_BIT);
  wire       rx_fe     = ~rx_in;
  wire       rx_brk    = rx_fe && (rx_shift_reg == 8'h00);
  // No parity here, so the parity flag stores zero
  assign rx_entry = {rx_brk, rx_fe, 1'b0, rx_shift_reg};
  assign rx_push  = rx_stop;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
        begin
          if (tick_reg && !rx_in)
          begin
            rx_os_reg    <= 4'h1;
            rx_bit_reg   <= 4'h0;
            rx_state_reg <= RX_RECV;
          end
        end
        RX_RECV:
        begin
          if (tick_reg)
            rx_os_reg <= rx_os_reg + 4'h1;
          if (rx_sample)
          begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && rx_in)
              rx_state_reg <= RX_IDLE;
            else if (rx_bit_reg == `FRAME_LAST_BIT)
              rx_state_reg <= RX_IDLE;
            else if (rx_bit_reg != 4'h0)
              rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
          end
        end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Overrun set wins over the clear by a status read
  always @(posedge sys_clk)
  begin
    if (!nrst)
      overrun_reg <= 1'b0;
    else
      overrun_reg <= (rx_push && !rxf_ready) || (overrun_reg && !rd_lsr_sel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger levels
  reg [6:0]  rx_fixed;
  reg [6:0]  tx_fixed;
  wire [6:0] rx_prog  = {1'b0, trigger_level_reg[7:4], 2'b00};
  wire [6:0] tx_prog  = {1'b0, trigger_level_reg[3:0], 2'b00};
  wire [6:0] rx_trig  = (rx_prog == 7'h00) ? rx_fixed : rx_prog;
  wire [6:0] tx_trig  = (tx_prog == 7'h00) ? tx_fixed : tx_prog;
  wire [6:0] rx_eff   = fifo_en ? rx_trig : `TRIG_SINGLE;
  wire [6:0] tx_eff   = fifo_en ? tx_trig : `TRIG_SINGLE;
  wire [6:0] tx_space = `FIFO_DEPTH - txf_level;

  always @*
  begin
    case (fifo_control_reg[7:6])
      2'b00:   rx_fixed = `RX_TRIG_0;
      2'b01:   rx_fixed = `RX_TRIG_1;
      2'b10:   rx_fixed = `RX_TRIG_2;
      default: rx_fixed = `RX_TRIG_3;
    endcase
    case (fifo_control_reg[5:4])
      2'b00:   tx_fixed = `TX_TRIG_0;
      2'b01:   tx_fixed = `TX_TRIG_1;
      2'b10:   tx_fixed = `TX_TRIG_2;
      default: tx_fixed = `TX_TRIG_3;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_trig_hit <= 1'b0;
      tx_trig_hit <= 1'b0;
    end
    else
    begin
      rx_trig_hit <= (rxf_level >= rx_eff);
      tx_trig_hit <= (tx_space >= tx_eff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Automatic request-to-send with halt/resume hysteresis
  wire [6:0] halt_prog   = {1'b0, flow_threshold_reg[3:0], 2'b00};
  wire [6:0] resume_prog = {1'b0, flow_threshold_reg[7:4], 2'b00};
  wire       thr_zero    = (flow_threshold_reg == 8'h00);
  wire [6:0] halt_lvl    = thr_zero ? rx_trig : halt_prog;
  wire [6:0] resume_lvl  = thr_zero ? rx_trig - 7'h01 : resume_prog;
  reg        halt_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst || !auto_rts)
      halt_reg <= 1'b0;
    else if (rxf_level >= halt_lvl)
      halt_reg <= 1'b1;
    else if (rxf_level <= resume_lvl)
      halt_reg <= 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
      rts_n_pin <= 1'b1;
    else if (auto_rts)
      rts_n_pin <= halt_reg | ~modem_control_reg[`MCR_RTS];
    else
      rts_n_pin <= ~modem_control_reg[`MCR_RTS];
  end

  // Idle high in loopback so the far side sees no traffic
  always @(posedge sys_clk)
  begin
    if (!nrst)
      tx_pin <= 1'b1;
    else
      tx_pin <= loopback ? 1'b1 : tx_line_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe, zero otherwise
  wire [7:0] line_stat = {1'b0, (tx_state_reg == TX_IDLE) && !txf_valid, !txf_valid,
                          rxf_data[10:8] & {3{rxf_valid}}, overrun_reg, rxf_valid};
  wire [7:0] modem_status_reg = {3'b000, cts_active, 4'h0};

  always @(posedge sys_clk)
  begin
    if (!nrst || !rd_stb)
      rdata <= 8'h00;
    else
    begin
      case (addr)
        `ADDR_DATA:       rdata <= rxf_valid ? rxf_data[7:0] : 8'h00;
        `ADDR_DIV_LO:     rdata <= div_lo_reg;
        `ADDR_DIV_HI:     rdata <= div_hi_reg;
        `ADDR_FIFO_CTRL:  rdata <= fifo_control_reg;
        `ADDR_MODEM_CTRL: rdata <= modem_control_reg;
        `ADDR_LINE_STAT:  rdata <= line_stat;
        `ADDR_MODEM_STAT: rdata <= modem_status_reg;
        `ADDR_ENH_FEAT:   rdata <= enhanced_feature_reg;
        `ADDR_FLOW_THR:   rdata <= flow_threshold_reg;
        `ADDR_TRIG_LVL:   rdata <= trigger_level_reg;
        `ADDR_TX_LEVEL:   rdata <= {1'b0, tx_space};
        `ADDR_RX_LEVEL:   rdata <= {1'b0, rxf_level};
        default:          rdata <= 8'h00;
      endcase
    end
  end

endmodule // uart_flow_ctrl

`default_nettype wire

// ===== logic/uart_flow_defines.vh
// Register offsets, field positions, reset values and timing counts
// for the UART flow-control block. Definitions only.
`ifndef UART_FLOW_DEFINES_VH
`define UART_FLOW_DEFINES_VH

// Register offsets
`define ADDR_DATA        4'h0
`define ADDR_DIV_LO      4'h1
`define ADDR_DIV_HI      4'h2
`define ADDR_FIFO_CTRL   4'h3
`define ADDR_MODEM_CTRL  4'h4
`define ADDR_LINE_STAT   4'h5
`define ADDR_MODEM_STAT  4'h6
`define ADDR_ENH_FEAT    4'h7
`define ADDR_FLOW_THR    4'h8
`define ADDR_TRIG_LVL    4'h9
`define ADDR_TX_LEVEL    4'ha
`define ADDR_RX_LEVEL    4'hb

// Field positions
`define FCR_FIFO_EN      0
`define FCR_RX_FLUSH     1
`define FCR_TX_FLUSH     2
`define MCR_RTS          1
`define MCR_LOOP         4
`define EFR_AUTO_RTS     6
`define EFR_AUTO_CTS     7
`define MSR_CTS          4

// Reset values
`define FCR_RST          8'h00
`define MCR_RST          8'h00
`define EFR_RST          8'h00
`define TCR_RST          8'h00
`define TLR_RST          8'h00
`define DIV_LO_RST       8'h01
`define DIV_HI_RST       8'h00

// FIFO geometry
`define FIFO_DEPTH       7'h40
`define FIFO_AW          6
`define RX_ENTRY_W       11

// Fixed trigger levels
`define RX_TRIG_0        7'h08
`define RX_TRIG_1        7'h10
`define RX_TRIG_2        7'h38
`define RX_TRIG_3        7'h3c
`define TX_TRIG_0        7'h08
`define TX_TRIG_1        7'h10
`define TX_TRIG_2        7'h20
`define TX_TRIG_3        7'h38
`define TRIG_SINGLE      7'h01

// Timing counts in baud ticks and frame bits
`define OVERSAMPLE_LAST  4'hf
`define SAMPLE_POINT     4'h7
`define FRAME_LAST_BIT   4'h9

`endif

// ===== test/far_uart.sv
// Remote UART model: decodes the transmit line, sends 8N1 characters.
// Assumes the bench sets the divisor and says when the far side is ready.
`timescale 1ns/10ps
`default_nettype none
module far_uart (
  input  wire logic        sys_clk,
  input  wire logic [15:0] div,
  input  wire logic        tx_line,
  input  wire logic        cts_ok,
  output var  logic        rx_line,
  output wire logic        cts_n,
  output var  logic [7:0]  got,
  output var  logic        got_stb
);
  // Low only while ready to take data
  assign cts_n = !cts_ok;
  initial
  begin
    rx_line = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // No stop-bit check; a lost frame shows as a missing byte
  always
  begin : rx_side
    integer i;
    @(negedge tx_line);
    repeat (8 * div) @(posedge sys_clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      repeat (16 * div) @(posedge sys_clk);
      got[i] = tx_line;
    end
    repeat (16 * div) @(posedge sys_clk);
    got_stb <= 1'b1;
    @(posedge sys_clk);
    got_stb <= 1'b0;
  end
  task automatic send(input logic [7:0] b);
    integer i;
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (16 * div) @(posedge sys_clk);
    for (i = 0; i < 8; i = i + 1)
    begin
      rx_line <= b[i];
      repeat (16 * div) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
    repeat (16 * div) @(posedge sys_clk);
  endtask
endmodule // far_uart
`default_nettype wire

// ===== test/test_uart_hw_flow_control_fifo_trigger.sv
// Self-checking bench for the UART flow-control block.
// Assumes the checker is bound in; 50 MHz clock, synchronous low reset.
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defines.vh"
module test_uart_hw_flow_control_fifo_trigger;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        cts_ok = 1'b0;
  logic [15:0] div = 16'h0001;
  logic [31:0] seed = 32'h2117;
  logic [7:0]  d;
  logic [7:0]  rxq[$];
  logic [7:0]  rx_exp[$];
  integer      error_cnt = 0;
  integer      tests_run = 0;
  integer      cyc = 0;
  integer      i;
  wire logic [7:0] rdata;
  wire logic [7:0] got;
  wire logic       rx_pin;
  wire logic       cts_n_pin;
  wire logic       tx_pin;
  wire logic       rts_n_pin;
  wire logic       rx_trig_hit;
  wire logic       tx_trig_hit;
  wire logic       got_stb;
  always #10 sys_clk = ~sys_clk;
  uart_flow_ctrl u_dut (.sys_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rx_pin,
    .cts_n_pin, .tx_pin, .rts_n_pin, .rx_trig_hit, .tx_trig_hit);
  far_uart u_far (.sys_clk, .div, .tx_line(tx_pin), .cts_ok, .rx_line(rx_pin),
    .cts_n(cts_n_pin), .got, .got_stb);
  always @(posedge sys_clk)
    if (got_stb)
      rxq.push_back(got);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask
  // Bounded wait for a far-side byte; a missing one counts as wrong
  task automatic rx_chk(input logic [7:0] e);
    integer k;
    for (k = 0; k < 3000 && rxq.size() == 0; k++)
      @(posedge sys_clk);
    chk((rxq.size() > 0) ? rxq.pop_front() : ~e, e);
  endtask
  task automatic pause(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pause(6);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chkb(rts_n_pin, 1'b1);
    rdchk(`ADDR_MODEM_CTRL, `MCR_RST);
    rdchk(`ADDR_ENH_FEAT, `EFR_RST);
    rdchk(`ADDR_DIV_LO, `DIV_LO_RST);
    rdchk(`ADDR_TX_LEVEL, 8'h40);
    rdchk(4'hf, 8'h00);
    wr(`ADDR_MODEM_CTRL, 8'h02);
    pause(3);
    chkb(rts_n_pin, 1'b0);
    wr(`ADDR_MODEM_CTRL, 8'h00);
    pause(3);
    chkb(rts_n_pin, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      cts_ok <= i[0];
      pause(8);
      rd(`ADDR_MODEM_STAT);
      chkb(d[`MSR_CTS], i[0]);
    end
    $display("reset test done");
    cts_ok <= 1'b0;
    div <= 16'h0003;
    wr(`ADDR_DIV_LO, 8'h03);
    seed = lfsr(seed);
    wr(`ADDR_DATA, seed[7:0]);
    rx_chk(seed[7:0]);
    $display("divisor test done");
    div <= 16'h0001;
    wr(`ADDR_DIV_LO, 8'h01);
    wr(`ADDR_ENH_FEAT, 8'h80);
    seed = lfsr(seed);
    wr(`ADDR_DATA, seed[7:0]);
    wr(`ADDR_DATA, seed[15:8]);
    pause(300);
    chkb(rxq.size() == 0, 1'b1);
    cts_ok <= 1'b1;
    pause(60);
    cts_ok <= 1'b0;
    rx_chk(seed[7:0]);
    pause(300);
    chkb(rxq.size() == 0, 1'b1);
    cts_ok <= 1'b1;
    rx_chk(seed[15:8]);
    $display("auto cts test done");
    wr(`ADDR_ENH_FEAT, 8'h00);
    wr(`ADDR_MODEM_CTRL, 8'h10);
    seed = lfsr(seed);
    wr(`ADDR_DATA, seed[7:0]);
    u_far.send(~seed[7:0]);
    pause(100);
    rdchk(`ADDR_DATA, seed[7:0]);
    chkb(rxq.size() == 0, 1'b1);
    rdchk(`ADDR_RX_LEVEL, 8'h00);
    wr(`ADDR_MODEM_CTRL, 8'h00);
    $display("test loopback done");
    wr(`ADDR_FLOW_THR, 8'h12);
    wr(`ADDR_MODEM_CTRL, 8'h02);
    wr(`ADDR_ENH_FEAT, 8'h40);
    pause(3);
    chkb(rts_n_pin, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      rx_exp.push_back(seed[7:0]);
      u_far.send(seed[7:0]);
      if (i == 6)
        chkb(rts_n_pin, 1'b0);
    end
    pause(8);
    chkb(rts_n_pin, 1'b1);
    chkb(rx_trig_hit, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      chkb(rts_n_pin, 1'b1);
      rd(`ADDR_DATA);
      chk(d, rx_exp.pop_front());
    end
    pause(3);
    chkb(rts_n_pin, 1'b0);
    wr(`ADDR_FLOW_THR, 8'h00);
    pause(3);
    chkb(rts_n_pin, 1'b0);
    wr(`ADDR_FIFO_CTRL, 8'h01);
    pause(3);
    chkb(rts_n_pin, 1'b0);
    chkb(rx_trig_hit, 1'b0);
    chkb(tx_trig_hit, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      rd(`ADDR_DATA);
      chk(d, rx_exp.pop_front());
    end
    rdchk(`ADDR_RX_LEVEL, 8'h00);
    $display("auto rts test done");
    cts_ok <= 1'b0;
    pause(8);
    wr(`ADDR_ENH_FEAT, 8'h80);
    for (i = 0; i < 65; i++)
    begin
      seed = lfsr(seed);
      wr(`ADDR_DATA, seed[7:0]);
    end
    rdchk(`ADDR_TX_LEVEL, 8'h00);
    chkb(tx_trig_hit, 1'b0);
    wr(`ADDR_FIFO_CTRL, 8'h05);
    rdchk(`ADDR_TX_LEVEL, 8'h40);
    $display("test fifo depth done");
    report_and_stop();
  end
endmodule // test_uart_hw_flow_control_fifo_trigger
`default_nettype wire

// ===== test/uart_flow_asserts.sv
// Port-level checker for the UART flow-control block.
// Assumes it is bound to uart_flow_ctrl; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "uart_flow_defines.vh"
module uart_flow_asserts (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       cts_n_pin,
  input wire logic       tx_pin,
  input wire logic       rts_n_pin,
  input wire logic       rx_trig_hit,
  input wire logic       tx_trig_hit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Mirrors rebuilt from strobes; counters give the pin synchronisers time
  logic [7:0] mcr_reg;
  logic [7:0] efr_reg;
  logic [2:0] cts_cnt_reg;
  logic [8:0] hi_cnt_reg;
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mcr_reg <= 8'h00;
      efr_reg <= 8'h00;
    end
    else if (wr_stb && addr == `ADDR_MODEM_CTRL)
      mcr_reg <= wdata;
    else if (wr_stb && addr == `ADDR_ENH_FEAT)
      efr_reg <= wdata;
    cts_cnt_reg <= !nrst || !$stable(cts_n_pin) ? 3'h0 : cts_cnt_reg + {2'h0, cts_cnt_reg != 3'h7};
    hi_cnt_reg <= !nrst || !tx_pin ? 9'h000 : hi_cnt_reg + {8'h00, hi_cnt_reg != 9'h1ff};
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_idle: assert property ($rose(nrst) |-> rts_n_pin && tx_pin)
    else $error("pins not idle after reset");
  chk_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_rd: assert property (rd_stb && addr > `ADDR_RX_LEVEL |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rts_manual: assert property (!efr_reg[`EFR_AUTO_RTS] && !mcr_reg[`MCR_LOOP] &&
    $stable(mcr_reg) && $stable(efr_reg) |-> rts_n_pin == !mcr_reg[`MCR_RTS])
    else $error("request pin not per control bit");
  chk_cts_status: assert property (rd_stb && addr == `ADDR_MODEM_STAT &&
    !mcr_reg[`MCR_LOOP] && cts_cnt_reg == 3'h7 |=> rdata[`MSR_CTS] == !$past(cts_n_pin))
    else $error("status bit wrong");
  // Long idle before the fall marks a new character
  chk_cts_gate: assert property ($fell(tx_pin) && hi_cnt_reg > 9'h190 |->
    !(efr_reg[`EFR_AUTO_CTS] && cts_n_pin && cts_cnt_reg == 3'h7))
    else $error("start while clear-to-send off");
  chk_loop_quiet: assert property (mcr_reg[`MCR_LOOP] && $past(mcr_reg[`MCR_LOOP]) |-> tx_pin)
    else $error("transmit pin active in loopback");
  chk_trig_reset: assert property ($rose(nrst) |-> !rx_trig_hit ##1 (tx_trig_hit && !rx_trig_hit))
    else $error("trigger flags wrong after reset");
  cov_cts_read: cover property (rd_stb && addr == `ADDR_MODEM_STAT);
  cov_auto_rts: cover property ($rose(rts_n_pin) && efr_reg[`EFR_AUTO_RTS]);
  cov_auto_cts: cover property ($fell(tx_pin) && efr_reg[`EFR_AUTO_CTS]);
endmodule // uart_flow_asserts
bind uart_flow_ctrl uart_flow_asserts u_chk (.sys_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .cts_n_pin, .tx_pin, .rts_n_pin, .rx_trig_hit, .tx_trig_hit);
`default_nettype wire
